// File: rtl/dds_src_pkg.sv
// Notes on behaviour
// - four modes: single tone, waveform memory, linear sweep, parallel port
// - single tone takes frequency, phase, amplitude from the programming registers
// - eight single-tone profiles, picked by the three-bit profile select
// - profile select change loads the chosen profile at next sync rising edge
// - parameters no source drives come from their programming registers
// - memory, sweep and parallel modes each drive one parameter; polar drives amplitude and phase
// - amplitude keying has its own linear ramp, touching only amplitude
// - enabled amplitude keying overrides every other amplitude source
// - modes may run together; fixed priority resolves competing sources
// - memory mode starts only after enable plus update or profile change
// - memory mode plays words from a 1024 by 32-bit waveform memory
// - programmable timer sets the waveform memory fetch rate
// - eight memory profiles set destination; switch at next sync rising edge
// - polar format splits a sample into 16-bit phase and 14-bit magnitude
// - sweep mode takes the modulated parameter from the linear sweep generator
// - parallel mode takes the modulated parameter from the parallel data words
// - update strobe moves all buffered writes into the active registers
// - sync clock runs at a quarter of the system clock
package dds_src_pkg;
    localparam int FTW_W = 32;
    localparam int POW_W = 16;
    localparam int ASF_W = 14;
    localparam int PROF_N = 8;
    localparam int PROF_W = 3;
    localparam int RAM_DEPTH = 1024;
    localparam int RAM_AW = 10;
    localparam int RAM_DW = 32;
    localparam int PDP_W = 16;
    localparam int FMG_W = 4;
    localparam int RATE_W = 16;
    localparam int WORD_W = FTW_W + POW_W + ASF_W;
    localparam logic [1:0] SYNC_RISE_CNT = 2'h1;
    localparam int PH_LSB = 16;
    localparam int AMP_LSB = 18;
    localparam int POLAR_MAG_LSB = 2;
    localparam int PDP_AMP_LSB = 2;
    localparam int PDP_HALF = 8;
    localparam logic [FTW_W-1:0] FTW_RST = 32'h0000_0000;
    localparam logic [POW_W-1:0] POW_RST = 16'h0000;
    localparam logic [ASF_W-1:0] ASF_RST = 14'h0000;
    localparam logic [RATE_W-1:0] RATE_RST = 16'h0000;

    typedef enum logic [1:0] {
        DEST_FREQ = 2'b00,
        DEST_PHASE = 2'b01,
        DEST_AMP = 2'b10,
        DEST_POLAR = 2'b11
    } dest_t;

    typedef enum logic [1:0] {
        PDP_AMP = 2'b00,
        PDP_PHASE = 2'b01,
        PDP_FREQ = 2'b10,
        PDP_POLAR = 2'b11
    } pdp_fmt_t;

    typedef enum logic {
        PLAY_IDLE = 1'b0,
        PLAY_RUN = 1'b1
    } play_state_t;
endpackage : dds_src_pkg

// File: rtl/wave_mem_if.sv
`timescale 1ns/100ps
interface wave_mem_if;
    logic wr_en;
    logic [dds_src_pkg::RAM_AW-1:0] wr_addr;
    logic [dds_src_pkg::RAM_DW-1:0] wr_data;
    logic rd_en;
    logic [dds_src_pkg::RAM_AW-1:0] rd_addr;
    logic [dds_src_pkg::RAM_DW-1:0] rd_data;

    modport ctrl (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
    modport mem (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface : wave_mem_if

// File: rtl/wave_mem.sv
`timescale 1ns/100ps
module wave_mem #(
    parameter int DEPTH = dds_src_pkg::RAM_DEPTH
) (
    input wire logic ref_clk,
    wave_mem_if.mem port
);
    logic [dds_src_pkg::RAM_DW-1:0] store [DEPTH];

    always_ff @(posedge ref_clk) begin
        if (port.wr_en) begin
            store[port.wr_addr] <= port.wr_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (port.rd_en) begin
            port.rd_data <= store[port.rd_addr];
        end
    end
endmodule : wave_mem

// File: rtl/dds_param_source_select.sv
`timescale 1ns/100ps
module dds_param_source_select (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // profile and update pins
    input wire logic [dds_src_pkg::PROF_W-1:0] profile_sel,
    input wire logic update,
    output logic sync_clk,
    // buffered mode control
    input wire logic ram_enable,
    input wire logic sweep_enable,
    input wire logic [1:0] sweep_dest,
    input wire logic pdp_enable,
    input wire logic [dds_src_pkg::FMG_W-1:0] fm_gain,
    input wire logic amplitude_keying_enable,
    input wire logic [dds_src_pkg::ASF_W-1:0] ak_step,
    // single-tone profile writes
    input wire logic tone_wr,
    input wire logic [dds_src_pkg::PROF_W-1:0] tone_wr_idx,
    input wire logic [dds_src_pkg::FTW_W-1:0] tone_ftw,
    input wire logic [dds_src_pkg::POW_W-1:0] tone_pow,
    input wire logic [dds_src_pkg::ASF_W-1:0] tone_asf,
    // waveform memory profile writes
    input wire logic mprof_wr,
    input wire logic [dds_src_pkg::PROF_W-1:0] mprof_wr_idx,
    input wire logic [dds_src_pkg::RAM_AW-1:0] mprof_start,
    input wire logic [dds_src_pkg::RAM_AW-1:0] mprof_end,
    input wire logic [dds_src_pkg::RATE_W-1:0] mprof_rate,
    input wire logic [1:0] mprof_dest,
    // waveform memory writes
    input wire logic ram_wr,
    input wire logic [dds_src_pkg::RAM_AW-1:0] ram_wr_addr,
    input wire logic [dds_src_pkg::RAM_DW-1:0] ram_wr_data,
    // modulation sources
    input wire logic [dds_src_pkg::FTW_W-1:0] linear_sweep_generator,
    input wire logic [dds_src_pkg::PDP_W-1:0] pdp_data,
    input wire logic [1:0] pdp_fmt,
    input wire logic pdp_valid,
    input wire logic amplitude_keying,
    // control words to the synthesis core
    output logic core_valid,
    input wire logic core_ready,
    output logic [dds_src_pkg::FTW_W-1:0] core_ftw,
    output logic [dds_src_pkg::POW_W-1:0] core_pow,
    output logic [dds_src_pkg::ASF_W-1:0] core_asf,
    // status
    output logic ram_active,
    output logic [dds_src_pkg::PROF_W-1:0] active_profile
);
    localparam int N = dds_src_pkg::PROF_N;
    localparam int FW = dds_src_pkg::FTW_W;
    localparam int PW = dds_src_pkg::POW_W;
    localparam int AW = dds_src_pkg::ASF_W;
    localparam int MW = dds_src_pkg::RAM_AW;
    localparam int RW = dds_src_pkg::RATE_W;

    ////////////////////////////////////////////////////////////////
    logic [1:0] div_ff;
    logic sync_rise;
    logic apply;
    logic [dds_src_pkg::PROF_W-1:0] prof_ff;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            div_ff <= 2'h0;
            sync_clk <= 1'b0;
        end else begin
            div_ff <= div_ff + 2'h1;
            sync_clk <= (div_ff == dds_src_pkg::SYNC_RISE_CNT) || (div_ff == 2'h2);
        end
    end

    assign sync_rise = (div_ff == dds_src_pkg::SYNC_RISE_CNT);
    assign apply = sync_rise && (update || (profile_sel != prof_ff));

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            prof_ff <= '0;
        end else if (apply) begin
            prof_ff <= profile_sel;
        end
    end
    assign active_profile = prof_ff;

    ////////////////////////////////////////////////////////////////
    logic [FW-1:0] buf_ftw [N];
    logic [PW-1:0] buf_pow [N];
    logic [AW-1:0] buf_asf [N];
    logic [FW-1:0] act_ftw [N];
    logic [PW-1:0] act_pow [N];
    logic [AW-1:0] act_asf [N];
    logic [MW-1:0] buf_start [N];
    logic [MW-1:0] buf_end [N];
    logic [RW-1:0] buf_rate [N];
    logic [1:0] buf_dest [N];
    logic [MW-1:0] act_start [N];
    logic [MW-1:0] act_end [N];
    logic [RW-1:0] act_rate [N];
    logic [1:0] act_dest [N];
    logic sweep_en_ff, pdp_en_ff, ak_en_ff;
    logic [1:0] sweep_dest_ff;
    logic [dds_src_pkg::FMG_W-1:0] fm_gain_ff;
    logic [AW-1:0] ak_step_ff;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < N; i++) begin
                buf_ftw[i] <= dds_src_pkg::FTW_RST;
                buf_pow[i] <= dds_src_pkg::POW_RST;
                buf_asf[i] <= dds_src_pkg::ASF_RST;
                buf_start[i] <= '0;
                buf_end[i] <= '0;
                buf_rate[i] <= dds_src_pkg::RATE_RST;
                buf_dest[i] <= dds_src_pkg::DEST_FREQ;
            end
        end else begin
            if (tone_wr) begin
                buf_ftw[tone_wr_idx] <= tone_ftw;
                buf_pow[tone_wr_idx] <= tone_pow;
                buf_asf[tone_wr_idx] <= tone_asf;
            end
            if (mprof_wr) begin
                buf_start[mprof_wr_idx] <= mprof_start;
                buf_end[mprof_wr_idx] <= mprof_end;
                buf_rate[mprof_wr_idx] <= mprof_rate;
                buf_dest[mprof_wr_idx] <= mprof_dest;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < N; i++) begin
                act_ftw[i] <= dds_src_pkg::FTW_RST;
                act_pow[i] <= dds_src_pkg::POW_RST;
                act_asf[i] <= dds_src_pkg::ASF_RST;
                act_start[i] <= '0;
                act_end[i] <= '0;
                act_rate[i] <= dds_src_pkg::RATE_RST;
                act_dest[i] <= dds_src_pkg::DEST_FREQ;
            end
            sweep_en_ff <= 1'b0;
            pdp_en_ff <= 1'b0;
            ak_en_ff <= 1'b0;
            sweep_dest_ff <= dds_src_pkg::DEST_FREQ;
            fm_gain_ff <= '0;
            ak_step_ff <= '0;
        end else if (apply) begin
            for (int i = 0; i < N; i++) begin
                act_ftw[i] <= buf_ftw[i];
                act_pow[i] <= buf_pow[i];
                act_asf[i] <= buf_asf[i];
                act_start[i] <= buf_start[i];
                act_end[i] <= buf_end[i];
                act_rate[i] <= buf_rate[i];
                act_dest[i] <= buf_dest[i];
            end
            sweep_en_ff <= sweep_enable;
            pdp_en_ff <= pdp_enable;
            ak_en_ff <= amplitude_keying_enable;
            sweep_dest_ff <= sweep_dest;
            fm_gain_ff <= fm_gain;
            ak_step_ff <= ak_step;
        end
    end

    ////////////////////////////////////////////////////////////////
    wave_mem_if mem_bus ();
    dds_src_pkg::play_state_t play_ff;
    logic [MW-1:0] addr_ff;
    logic [RW-1:0] timer_ff;
    logic rd_pend_ff;
    logic [dds_src_pkg::RAM_DW-1:0] sample_ff;
    logic fill_ok;

    wave_mem #(
        .DEPTH(dds_src_pkg::RAM_DEPTH)
    ) u_wave_mem (
        .ref_clk(ref_clk),
        .port(mem_bus.mem)
    );

    assign mem_bus.wr_en = ram_wr;
    assign mem_bus.wr_addr = ram_wr_addr;
    assign mem_bus.wr_data = ram_wr_data;
    assign mem_bus.rd_addr = addr_ff;
    assign mem_bus.rd_en = (play_ff == dds_src_pkg::PLAY_RUN) && (timer_ff == '0) && fill_ok;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            play_ff <= dds_src_pkg::PLAY_IDLE;
            addr_ff <= '0;
            timer_ff <= '0;
        end else if (apply) begin
            play_ff <= ram_enable ? dds_src_pkg::PLAY_RUN : dds_src_pkg::PLAY_IDLE;
            addr_ff <= buf_start[profile_sel];
            timer_ff <= '0;
        end else begin
            case (play_ff)
                dds_src_pkg::PLAY_RUN: begin
                    // a full output buffer freezes playback so no sample is skipped
                    if (fill_ok) begin
                        if (timer_ff == '0) begin
                            timer_ff <= act_rate[prof_ff];
                            addr_ff <= (addr_ff == act_end[prof_ff]) ?
                                act_start[prof_ff] : addr_ff + 1'b1;
                        end else begin
                            timer_ff <= timer_ff - 1'b1;
                        end
                    end
                end
                default: begin
                    timer_ff <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rd_pend_ff <= 1'b0;
            sample_ff <= '0;
        end else begin
            rd_pend_ff <= mem_bus.rd_en;
            if (rd_pend_ff) begin
                sample_ff <= mem_bus.rd_data;
            end
        end
    end
    assign ram_active = (play_ff == dds_src_pkg::PLAY_RUN);

    ////////////////////////////////////////////////////////////////
    // amplitude keying ramp, stepped once per sync period
    logic [AW-1:0] ak_level_ff;
    logic [AW:0] ak_up;
    logic [AW-1:0] ak_target;

    assign ak_target = act_asf[prof_ff];
    assign ak_up = {1'b0, ak_level_ff} + {1'b0, ak_step_ff};

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ak_level_ff <= '0;
        end else if (sync_rise && fill_ok) begin
            if (amplitude_keying) begin
                ak_level_ff <= (ak_up >= {1'b0, ak_target}) ? ak_target : ak_up[AW-1:0];
            end else begin
                ak_level_ff <= (ak_level_ff > ak_step_ff) ? ak_level_ff - ak_step_ff : '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // source selection: keying > memory > sweep > parallel port > profile
    logic [FW-1:0] nxt_ftw;
    logic [PW-1:0] nxt_pow;
    logic [AW-1:0] nxt_asf;
    logic [FW-1:0] pdp_offset;

    assign pdp_offset = {{(FW-dds_src_pkg::PDP_W){1'b0}}, pdp_data} << fm_gain_ff;

    always_comb begin
        nxt_ftw = act_ftw[prof_ff];
        nxt_pow = act_pow[prof_ff];
        nxt_asf = act_asf[prof_ff];
        if (pdp_en_ff && pdp_valid) begin
            case (pdp_fmt)
                dds_src_pkg::PDP_AMP: nxt_asf = pdp_data[dds_src_pkg::PDP_W-1:dds_src_pkg::PDP_AMP_LSB];
                dds_src_pkg::PDP_PHASE: nxt_pow = pdp_data;
                dds_src_pkg::PDP_FREQ: nxt_ftw = act_ftw[prof_ff] + pdp_offset;
                default: begin
                    nxt_asf = {pdp_data[dds_src_pkg::PDP_W-1:dds_src_pkg::PDP_HALF],
                        act_asf[prof_ff][AW-dds_src_pkg::PDP_HALF-1:0]};
                    nxt_pow = {pdp_data[dds_src_pkg::PDP_HALF-1:0],
                        act_pow[prof_ff][PW-dds_src_pkg::PDP_HALF-1:0]};
                end
            endcase
        end
        if (sweep_en_ff) begin
            case (sweep_dest_ff)
                dds_src_pkg::DEST_FREQ: nxt_ftw = linear_sweep_generator;
                dds_src_pkg::DEST_PHASE: nxt_pow = linear_sweep_generator[FW-1:dds_src_pkg::PH_LSB];
                default: nxt_asf = linear_sweep_generator[FW-1:dds_src_pkg::AMP_LSB];
            endcase
        end
        if (play_ff == dds_src_pkg::PLAY_RUN) begin
            case (act_dest[prof_ff])
                dds_src_pkg::DEST_FREQ: nxt_ftw = sample_ff;
                dds_src_pkg::DEST_PHASE: nxt_pow = sample_ff[FW-1:dds_src_pkg::PH_LSB];
                dds_src_pkg::DEST_AMP: nxt_asf = sample_ff[FW-1:dds_src_pkg::AMP_LSB];
                default: begin
                    nxt_pow = sample_ff[FW-1:dds_src_pkg::PH_LSB];
                    nxt_asf = sample_ff[dds_src_pkg::PH_LSB-1:dds_src_pkg::POLAR_MAG_LSB];
                end
            endcase
        end
        if (ak_en_ff) begin
            nxt_asf = ak_level_ff;
        end
    end

    ////////////////////////////////////////////////////////////////
    // two-entry buffer toward the core; one word per sync period
    logic [dds_src_pkg::WORD_W-1:0] slot_ff [2];
    logic wptr_ff, rptr_ff;
    logic [1:0] count_ff;
    logic push, pop;

    assign fill_ok = (count_ff != 2'h2);
    assign push = sync_rise && fill_ok;
    assign pop = core_valid && core_ready;
    assign core_valid = (count_ff != 2'h0);
    assign {core_ftw, core_pow, core_asf} = slot_ff[rptr_ff];

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            slot_ff[0] <= '0;
            slot_ff[1] <= '0;
            wptr_ff <= 1'b0;
        end else if (push) begin
            slot_ff[wptr_ff] <= {nxt_ftw, nxt_pow, nxt_asf};
            wptr_ff <= ~wptr_ff;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rptr_ff <= 1'b0;
            count_ff <= 2'h0;
        end else begin
            if (pop) begin
                rptr_ff <= ~rptr_ff;
            end
            count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : dds_param_source_select

// File: verif/dds_src_chk.sv
`timescale 1ns/100ps
module dds_src_chk (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // profile pins
    input wire logic [2:0] profile_sel,
    input wire logic ram_enable,
    input wire logic sync_clk,
    // core side
    input wire logic core_valid,
    input wire logic core_ready,
    input wire logic [31:0] core_ftw,
    input wire logic [15:0] core_pow,
    input wire logic [13:0] core_asf,
    // status
    input wire logic ram_active,
    input wire logic [2:0] active_profile
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////
    sequence sync_edge;
        $rose(sync_clk);
    endsequence
    sequence sync_rest;
        sync_clk ##1 !sync_clk [*2] ##1 sync_clk;
    endsequence
    a_sync_quarter: assert property (sync_edge |=> sync_rest)
        else $error("sync clock period wrong");
    a_profile_on_sync: assert property (!$stable(active_profile) |-> sync_edge)
        else $error("profile changed off the sync edge");
    a_profile_follows: assert property (sync_edge |-> active_profile == $past(profile_sel))
        else $error("profile not taken at sync edge");
    a_ram_on_apply: assert property ($changed(ram_active) |-> sync_edge)
        else $error("memory mode changed off the sync edge");
    a_ram_needs_enable: assert property ($rose(ram_active) |-> $past(ram_enable))
        else $error("memory mode without enable");
    a_word_held: assert property (core_valid && !core_ready |=>
        core_valid && $stable(core_ftw) && $stable(core_pow) && $stable(core_asf))
        else $error("stalled word not held");
    a_push_on_sync: assert property ($rose(core_valid) |-> sync_edge)
        else $error("word pushed off the sync edge");
    a_empty_push: assert property (sync_edge ##0 !$past(core_valid) |-> core_valid)
        else $error("no word pushed into empty buffer");
endmodule : dds_src_chk

bind dds_param_source_select dds_src_chk u_chk (
    .ref_clk, .rstn, .profile_sel, .ram_enable, .sync_clk, .core_valid, .core_ready,
    .core_ftw, .core_pow, .core_asf, .ram_active, .active_profile
);

// File: verif/ctl_model.sv
`timescale 1ns/100ps
module ctl_model (
    // clocks from the device
    input wire logic ref_clk,
    input wire logic sync_clk,
    // pins to the device
    output logic [2:0] profile_sel,
    output logic update
);
    logic [2:0] cur_sel;
    initial begin
        profile_sel = 3'h0;
        update = 1'b0;
        cur_sel = 3'h0;
    end
    // set up after the fall so the level is steady across the next rise
    task automatic apply(input logic [2:0] sel, input logic upd);
        @(negedge sync_clk);
        profile_sel <= sel;
        update <= upd;
        cur_sel = sel;
        @(posedge sync_clk);
        update <= 1'b0;
    endtask : apply
    task automatic glitch(input logic [2:0] sel);
        @(posedge sync_clk);
        profile_sel <= sel;
        update <= 1'b1;
        @(posedge ref_clk);
        profile_sel <= cur_sel;
        update <= 1'b0;
    endtask : glitch
endmodule : ctl_model

// File: verif/tb.sv
`timescale 1ns/100ps
module tb;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic core_ready = 1'b1;
    logic update, sync_clk, ram_enable, sweep_enable, pdp_enable, amplitude_keying_enable;
    logic tone_wr, mprof_wr, ram_wr, pdp_valid, amplitude_keying, core_valid, ram_active;
    logic [2:0] profile_sel, tone_wr_idx, mprof_wr_idx, active_profile;
    logic [1:0] sweep_dest, mprof_dest, pdp_fmt, mi;
    logic [3:0] fm_gain;
    logic [13:0] ak_step, tone_asf, core_asf, wa, prev;
    logic [15:0] tone_pow, mprof_rate, pdp_data, core_pow, wp;
    logic [31:0] tone_ftw, ram_wr_data, linear_sweep_generator, core_ftw, wf;
    logic [9:0] mprof_start, mprof_end, ram_wr_addr;
    int n_fail = 0;
    int check_count = 0;
    localparam logic [31:0] nf = 32'h1234_5678;
    localparam logic [15:0] np = 16'h4321;
    localparam logic [13:0] na = 14'h0a00;

    dds_param_source_select dut (
        .ref_clk, .rstn, .profile_sel, .update, .sync_clk, .ram_enable, .sweep_enable,
        .sweep_dest, .pdp_enable, .fm_gain, .amplitude_keying_enable, .ak_step, .tone_wr,
        .tone_wr_idx, .tone_ftw, .tone_pow, .tone_asf, .mprof_wr, .mprof_wr_idx, .mprof_start,
        .mprof_end, .mprof_rate, .mprof_dest, .ram_wr, .ram_wr_addr, .ram_wr_data,
        .linear_sweep_generator, .pdp_data, .pdp_fmt, .pdp_valid, .amplitude_keying,
        .core_valid, .core_ready, .core_ftw, .core_pow, .core_asf, .ram_active, .active_profile
    );
    ctl_model ctl (.ref_clk, .sync_clk, .profile_sel, .update);

    always #5 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] tf(input int k);
        return {8'(k + 1), 24'h0000a5};
    endfunction : tf
    function automatic logic [15:0] tp(input int k);
        return {4'(k), 12'h3c0};
    endfunction : tp
    function automatic logic [13:0] ta(input int k);
        return {4'(k + 1), 10'h155};
    endfunction : ta
    function automatic logic [31:0] mw(input logic [1:0] i);
        return {16'h1000 + 16'(i), 16'h2000 + 16'(i) * 16'h0004};
    endfunction : mw

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic chk_word(input string what, input logic [31:0] f, input logic [15:0] p,
            input logic [13:0] a);
        chk({what, " ftw"}, f, wf);
        chk({what, " pow"}, 32'(p), 32'(wp));
        chk({what, " asf"}, 32'(a), 32'(wa));
    endtask : chk_word
    ////////////////////////////////////////////////////////////////
    task automatic pop();
        int i;
        i = 0;
        do begin
            @(negedge ref_clk);
            i++;
        end while ((core_valid !== 1'b1 || core_ready !== 1'b1) && i < 64);
        if (i >= 64) begin
            n_fail++;
            $display("MISMATCH core word expected valid seen none");
            complete_run();
        end
        wf = core_ftw;
        wp = core_pow;
        wa = core_asf;
        @(posedge ref_clk);
    endtask : pop
    // core_ready is high, so only the word pushed on the apply edge itself was sampled before the apply
    task automatic word();
        repeat (3) pop();
    endtask : word
    task automatic tone_write(input int k, input logic [31:0] f, input logic [15:0] p,
            input logic [13:0] a);
        @(posedge ref_clk);
        tone_wr <= 1'b1;
        tone_wr_idx <= 3'(k);
        tone_ftw <= f;
        tone_pow <= p;
        tone_asf <= a;
        @(posedge ref_clk);
        tone_wr <= 1'b0;
    endtask : tone_write
    task automatic mprof_write(input int k, input logic [1:0] dest);
        @(posedge ref_clk);
        mprof_wr <= 1'b1;
        mprof_wr_idx <= 3'(k);
        mprof_start <= 10'h010;
        mprof_end <= 10'h013;
        mprof_rate <= 16'h0003;
        mprof_dest <= dest;
        @(posedge ref_clk);
        mprof_wr <= 1'b0;
    endtask : mprof_write
    task automatic ram_write(input logic [1:0] i);
        @(posedge ref_clk);
        ram_wr <= 1'b1;
        ram_wr_addr <= 10'h010 + 10'(i);
        ram_wr_data <= mw(i);
        @(posedge ref_clk);
        ram_wr <= 1'b0;
    endtask : ram_write
    // rep allows a repeated sample, never a skipped one
    task automatic mem_run(input bit polar, input bit rep);
        logic [31:0] m;
        repeat (6) begin
            pop();
            m = polar ? {wp, 16'h0000} : wf;
            mi = (rep && m[17:16] == mi) ? mi : mi + 2'h1;
            m = mw(mi);
            if (polar)
                chk_word("polar", tf(2), m[31:16], m[15:2]);
            else
                chk_word("memory", m, tp(1), ta(1));
        end
    endtask : mem_run
    ////////////////////////////////////////////////////////////////
    initial begin
        {ram_enable, sweep_enable, sweep_dest, pdp_enable, fm_gain, amplitude_keying_enable,
            ak_step, tone_wr, tone_wr_idx, tone_ftw, tone_pow, tone_asf, mprof_wr, mprof_wr_idx,
            mprof_start, mprof_end, mprof_rate, mprof_dest, ram_wr, ram_wr_addr, ram_wr_data,
            linear_sweep_generator, pdp_data, pdp_fmt, pdp_valid, amplitude_keying} = '0;
        repeat (4) @(posedge ref_clk);
        chk("reset", 32'h0, 32'({sync_clk, core_valid, ram_active, active_profile}));
        rstn <= 1'b1;
        for (int k = 0; k < 8; k++)
            tone_write(k, tf(k), tp(k), ta(k));
        ctl.apply(3'h0, 1'b1);
        word();
        chk_word("tone", tf(0), tp(0), ta(0));
        for (int k = 1; k < 8; k++) begin
            ctl.apply(3'(k), 1'b0);
            word();
            chk("profile", 32'(k), 32'(active_profile));
            chk_word("tone", tf(k), tp(k), ta(k));
        end
        ctl.apply(3'h0, 1'b0);
        tone_write(0, nf, np, na);
        word();
        chk_word("buffered", tf(0), tp(0), ta(0));
        ctl.glitch(3'h5);
        word();
        chk("glitch profile", 32'h0, 32'(active_profile));
        chk_word("glitch", tf(0), tp(0), ta(0));
        ctl.apply(3'h0, 1'b1);
        word();
        chk_word("update", nf, np, na);
        linear_sweep_generator <= 32'h9abc_def4;
        sweep_enable <= 1'b1;
        for (int d = 0; d < 3; d++) begin
            sweep_dest <= 2'(d);
            ctl.apply(3'h0, 1'b1);
            word();
            chk_word("sweep", d == 0 ? 32'h9abc_def4 : nf, d == 1 ? 16'h9abc : np,
                d == 2 ? 14'h26af : na);
        end
        sweep_enable <= 1'b0;
        pdp_enable <= 1'b1;
        pdp_valid <= 1'b1;
        pdp_data <= 16'hb6d5;
        fm_gain <= 4'h3;
        for (int f = 0; f < 4; f++) begin
            pdp_fmt <= 2'(f);
            ctl.apply(3'h0, 1'b1);
            word();
            chk_word("parallel", f == 2 ? nf + 32'h0005_b6a8 : nf,
                f == 1 ? 16'hb6d5 : (f == 3 ? 16'hd521 : np),
                f == 0 ? 14'h2db5 : (f == 3 ? 14'h2d80 : na));
        end
        sweep_enable <= 1'b1;
        sweep_dest <= 2'h0;
        pdp_fmt <= 2'h2;
        ctl.apply(3'h0, 1'b1);
        word();
        chk_word("priority", 32'h9abc_def4, np, na);
        sweep_dest <= 2'h2;
        pdp_fmt <= 2'h0;
        amplitude_keying_enable <= 1'b1;
        ak_step <= 14'h0100;
        amplitude_keying <= 1'b1;
        ctl.apply(3'h0, 1'b1);
        word();
        prev = wa;
        repeat (14) begin
            pop();
            chk("keying step", 32'h1, 32'(wa >= prev && wa - prev <= 14'h0100));
            prev = wa;
        end
        chk_word("keying top", nf, np, na);
        amplitude_keying <= 1'b0;
        repeat (14) pop();
        chk_word("keying low", nf, np, 14'h0000);
        amplitude_keying_enable <= 1'b0;
        ctl.apply(3'h0, 1'b1);
        word();
        chk_word("keying off", nf, np, 14'h26af);
        sweep_enable <= 1'b0;
        pdp_enable <= 1'b0;
        for (int i = 0; i < 4; i++)
            ram_write(2'(i));
        mprof_write(1, 2'h0);
        mprof_write(2, 2'h3);
        ram_enable <= 1'b1;
        repeat (12) @(posedge ref_clk);
        chk("memory idle", 32'h0, 32'(ram_active));
        ctl.apply(3'h1, 1'b0);
        word();
        pop();
        chk("memory on", 32'h1, 32'(ram_active));
        mi = wf[17:16];
        mem_run(1'b0, 1'b0);
        core_ready <= 1'b0;
        repeat (40) @(posedge ref_clk);
        chk("stall", 32'h1, 32'(core_valid));
        core_ready <= 1'b1;
        mem_run(1'b0, 1'b1);
        ctl.apply(3'h2, 1'b0);
        word();
        pop();
        chk("memory profile", 32'h2, 32'(active_profile));
        mi = wp[1:0];
        mem_run(1'b1, 1'b0);
        ram_enable <= 1'b0;
        ctl.apply(3'h0, 1'b1);
        word();
        chk("memory off", 32'h0, 32'(ram_active));
        chk_word("tone back", nf, np, na);
        complete_run();
    end
    initial begin
        repeat (60000) @(posedge ref_clk);
        n_fail++;
        $display("MISMATCH run expected end seen hang");
        complete_run();
    end
endmodule : tb
